/* File: bench/boundary_scan_test_registers_test.sv */
// Purpose: Self-checking bench for the boundary scan test registers
// Assumes: Pin inputs settle well before any capture
// Notes:   Register length is found by where a lone one emerges
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_test_registers_test;
    import bst_pkg::*;

    logic        clk_sys;
    logic        sys_rst;
    bst_tap_t    tap;
    logic        tdo;
    logic        tdo_en;
    logic [7:0]  pin_data_in;
    logic [1:0]  pin_oe_n_in;
    logic [7:0]  pin_data_out;
    logic [7:0]  pin_data_oe;
    logic        test_mode;
    int          n_mismatch;
    int          cmp_count;
    int          cycles;
    int          en_cnt;
    logic [19:0] got;

    bst_test_regs dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .tap(tap), .tdo(tdo),
        .tdo_en(tdo_en), .pin_data_in(pin_data_in),
        .pin_oe_n_in(pin_oe_n_in), .pin_data_out(pin_data_out),
        .pin_data_oe(pin_data_oe), .test_mode(test_mode)
    );
    bst_tap_model u_tap (.clk_sys(clk_sys), .tap(tap), .tdo(tdo));

    always #4 clk_sys = ~clk_sys;

    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // Generous ceiling; the whole run needs about one thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (tdo_en === 1'b1) begin
            en_cnt <= en_cnt + 1;
        end
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input logic [19:0] g, input logic [19:0] e,
                       input string what);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask : chk

    function automatic int sel_len(input logic [6:0] o);
        case (o)
            7'h00, 7'h02, 7'h03, 7'h0A, 7'h0B, 7'h0C: return 18;
            7'h0E, 7'h0F: return 2;
            default: return 1;
        endcase
    endfunction : sel_len

    function automatic logic is_test(input logic [6:0] o);
        case (o)
            7'h00, 7'h03, 7'h07, 7'h09, 7'h0B, 7'h0D, 7'h0F: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_test

    task automatic load_ir(input logic [7:0] op);
        u_tap.scan(1'b1, 8, {12'h000, op}, 1'b1, got);
    endtask : load_ir

    task automatic settle();
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    task automatic t_reset_state();
        int base;
        settle();
        chk(test_mode, 0, "mode after reset");
        chk(pin_data_out, 8'h5A, "normal buffer data");
        chk(pin_data_oe, 8'hF0, "normal buffer enable");
        base = en_cnt;
        load_ir(8'hFF);
        chk(got[7:0], 8'h81, "instruction capture");
        u_tap.scan(1'b0, 2, 20'h0_0003, 1'b1, got);
        chk(got[1:0], 2'b10, "shortcut capture");
        settle();
        chk(en_cnt - base, 10, "serial enable cycles");
    endtask : t_reset_state

    task automatic t_decode();
        logic [7:0] op;
        int         len;
        for (int k = 0; k < 18; k++) begin
            op  = 8'(k) | (k[0] ? 8'h80 : 8'h00);
            len = sel_len(op[6:0]);
            load_ir(op);
            settle();
            if (op[6:0] == OPC_FLOAT) begin
                chk(pin_data_oe, 0, "float enables");
            end else begin
                chk(test_mode, is_test(op[6:0]), "decoded mode");
            end
            u_tap.scan(1'b0, 19, 20'h0_0001, 1'b0, got);
            chk(got >> len, 20'h0_0001, "selected length");
        end
    endtask : t_decode

    task automatic t_boundary();
        pin_data_in <= 8'hC3;
        pin_oe_n_in <= 2'b10;
        load_ir(8'h80);
        settle();
        u_tap.scan(1'b0, 18, {2'b00, 2'b01, 8'h3C, 8'h96}, 1'b1, got);
        chk(got[17:0], {2'b10, 8'hC3, 8'hFF}, "chain capture");
        settle();
        chk(pin_data_out, 8'h96, "scanned outputs");
        chk(pin_data_oe, 8'hF0, "scanned enables");
        u_tap.scan(1'b0, 18, {2'b00, 2'b11, 8'h5A, 8'h0F}, 1'b1, got);
        chk(got[17:0], {2'b10, 8'hC3, 8'hC3}, "core from cells");
        settle();
        chk(pin_data_oe, 0, "enables off");
    endtask : t_boundary

    task automatic t_opsel_reset();
        u_tap.tlr();
        load_ir({1'b0, OPC_OPSEL_N});
        u_tap.scan(1'b0, 2, 20'h0_0001, 1'b1, got);
        chk(got[1:0], 2'b10, "select reset value");
        u_tap.scan(1'b0, 2, 20'h0_0003, 1'b1, got);
        chk(got[1:0], 2'b01, "select held");
        u_tap.tlr();
        settle();
        chk(test_mode, 0, "mode after tlr");
        load_ir({1'b0, OPC_READ_N});
        u_tap.scan(1'b0, 18, 20'h0_0000, 1'b1, got);
        chk(got[17:0], {2'b11, 8'h5A, 8'h0F}, "chain kept");
        load_ir({1'b0, OPC_OPSEL_N});
        u_tap.scan(1'b0, 2, 20'h0_0000, 1'b1, got);
        chk(got[1:0], 2'b10, "select after tlr");
    endtask : t_opsel_reset

    task automatic t_run_sample();
        load_ir({1'b0, OPC_RUN_BOUNDARY_TEST});
        u_tap.run(3);
        load_ir({1'b0, OPC_READ_N});
        u_tap.scan(1'b0, 18, 20'h0_0000, 1'b1, got);
        chk(got[17:0], {2'b00, 8'hC3, 8'hFF}, "sample toggle run");
    endtask : t_run_sample

    // One pattern step from seed 8001: top bit out, taps folded in
    task automatic t_run_pattern();
        load_ir({1'b0, OPC_SAMPLE});
        u_tap.scan(1'b0, 18, 20'h0_8001, 1'b1, got);
        load_ir({1'b0, OPC_OPSEL_N});
        u_tap.scan(1'b0, 2, 20'h0_0001, 1'b1, got);
        load_ir({1'b0, OPC_RUN_BOUNDARY_TEST});
        u_tap.run(1);
        load_ir({1'b0, OPC_READ_N});
        u_tap.scan(1'b0, 18, 20'h0_0000, 1'b1, got);
        chk(got[17:0], {2'b00, 16'h0002 ^ TAPS16}, "pattern step");
    endtask : t_run_pattern

    initial begin
        clk_sys     = 1'b0;
        sys_rst     = 1'b1;
        pin_data_in = 8'hA5;
        pin_oe_n_in = 2'b01;
        n_mismatch  = 0;
        cmp_count   = 0;
        cycles      = 0;
        en_cnt      = 0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_reset_state();
        t_decode();
        t_boundary();
        t_opsel_reset();
        t_run_sample();
        t_run_pattern();
        summarize();
    end
endmodule : boundary_scan_test_registers_test
`default_nettype wire

/* File: bench/bst_tap_model.sv */
// Purpose: Behavioural test controller that drives the TAP state strobes
// Assumes: One strobe per cycle, applied at the rising clk_sys edge
// Notes:   Scan tasks are called from the bench by hierarchical name
`timescale 1ns/10ps
`default_nettype none
module bst_tap_model (
    input  wire logic              clk_sys,
    output var  bst_pkg::bst_tap_t tap,
    input  wire logic              tdo
);
    import bst_pkg::*;

    initial tap = '0;

    task automatic cyc(input bst_tap_t v);
        @(posedge clk_sys);
        tap <= v;
    endtask : cyc

    // Capture, n shifts lsb first, optional update; tdo read mid-cycle
    task automatic scan(input logic ir, input int n, input logic [19:0] din,
                        input logic upd, output logic [19:0] dout);
        bst_tap_t v;
        dout = '0;
        v = '0;
        v.capture_ir = ir;
        v.capture_dr = ~ir;
        cyc(v);
        for (int i = 0; i <= n; i++) begin
            v = '0;
            if (i < n) begin
                v.tdi      = din[i];
                v.shift_ir = ir;
                v.shift_dr = ~ir;
            end else begin
                v.update_ir = ir & upd;
                v.update_dr = ~ir & upd;
            end
            cyc(v);
            if (i > 0) begin
                @(negedge clk_sys);
                dout[i-1] = tdo;
            end
        end
        cyc('0);
    endtask : scan

    task automatic run(input int k);
        bst_tap_t v;
        v = '0;
        v.run_idle = 1'b1;
        repeat (k) cyc(v);
        cyc('0);
    endtask : run

    task automatic tlr();
        bst_tap_t v;
        v = '0;
        v.tlr = 1'b1;
        cyc(v);
        cyc('0);
    endtask : tlr
endmodule : bst_tap_model
`default_nettype wire

/* File: core/bst_pkg.sv */
// Purpose: Shared constants and types for the boundary scan test registers
// Assumes: An external TAP controller supplies one-cycle state strobes
// Notes:   Opcode values ignore the top instruction bit
package bst_pkg;
    localparam int CHAIN_W = 18;
    localparam int OE_HI   = 17;
    localparam int OE_LO   = 16;
    localparam int IN_HI   = 15;
    localparam int IN_LO   = 8;
    localparam int OUT_HI  = 7;
    localparam int OUT_LO  = 0;
    localparam int IR_W    = 8;
    localparam int OPC_W   = 7;
    localparam int OPS_W   = 2;

    localparam logic [IR_W-1:0] IR_RESET   = 8'hFF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;

    localparam logic [OPC_W-1:0] OPC_EXTEST   = 7'h00;
    localparam logic [OPC_W-1:0] OPC_SAMPLE   = 7'h02;
    localparam logic [OPC_W-1:0] OPC_INTEST   = 7'h03;
    localparam logic [OPC_W-1:0] OPC_FLOAT    = 7'h06;
    localparam logic [OPC_W-1:0] OPC_HOLD     = 7'h07;
    localparam logic [OPC_W-1:0] OPC_RUN_BOUNDARY_TEST     = 7'h09;
    localparam logic [OPC_W-1:0] OPC_READ_N   = 7'h0A;
    localparam logic [OPC_W-1:0] OPC_READ_T   = 7'h0B;
    localparam logic [OPC_W-1:0] OPC_SELFCHK  = 7'h0C;
    localparam logic [OPC_W-1:0] OPC_TOGGLE   = 7'h0D;
    localparam logic [OPC_W-1:0] OPC_OPSEL_N  = 7'h0E;
    localparam logic [OPC_W-1:0] OPC_OPSEL_T  = 7'h0F;

    localparam logic [OPS_W-1:0] OPSEL_RESET  = 2'h2;
    localparam logic [OPS_W-1:0] OPS_TOGGLE   = 2'h0;
    localparam logic [OPS_W-1:0] OPS_PATTERN  = 2'h1;
    localparam logic [OPS_W-1:0] OPS_SIGN     = 2'h2;
    localparam logic [OPS_W-1:0] OPS_BOTH     = 2'h3;

    // Galois feedback taps; with the left shift and no tap on bit 0 they do not give maximal length
    localparam logic [15:0] TAPS16 = 16'hB400;
    localparam logic [7:0]  TAPS8  = 8'hB8;

    typedef enum logic [2:0] {
        DS_CHAIN = 3'b001,
        DS_SHORT = 3'b010,
        DS_OPSEL = 3'b100
    } bst_dsel_t;

    typedef enum logic [2:0] {
        MD_NORMAL = 3'b001,
        MD_TEST   = 3'b010,
        MD_FLOAT  = 3'b100
    } bst_mode_t;

    typedef struct packed {
        logic tlr;
        logic run_idle;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
        logic tdi;
    } bst_tap_t;
endpackage : bst_pkg

/* File: core/bst_test_regs.sv */
// Purpose: Test data registers and instruction decode of an octal buffer
// Assumes: TAP strobes come from logic on clk_sys; pins are asynchronous
// Notes:   Falling-edge update of the shadows is taken one clock later
// Notes on behaviour
// - Eighteen-cell chain, one cell per input and output pin.
// - Instruction picks capture source; run-test may alter chain.
// - Chain untouched in test-logic-reset.
// - Serial input enters bit 17; bit 0 feeds serial output.
// - Bits 17-16 enables, 15-8 data inputs, 7-0 data outputs.
// - Two-bit operation select steers run-boundary-test operation.
// - Operation select holds its value at capture.
// - Operation select resets to binary 10, signature compress.
// - Shortcut stage is one bit and captures zero.
// - Top opcode bit ignored by decode.
// - Opcodes 00 and 03 select chain in test mode.
// - Boundary scan captures input pins and core outputs.
// - Boundary scan drives core inputs and output pins from cells.
// - Sample, read and self check opcodes select chain per mode.
// - Float, hold, run and toggle opcodes select shortcut stage.
// - Opcodes 0E and 0F scan operation select, normal/test.
// - Unlisted and unknown opcodes select shortcut in normal mode.
// - Shortcut instruction leaves buffer function undisturbed.
// - Eight-bit instruction holder resets to all ones.
// - Instruction capture loads binary 10000001.
// - Select codes: toggle, pattern, signature, combined 8-bit.
// - Shadow latches load after update strobe when chain data register updates.
`timescale 1ns/10ps
`default_nettype none
module bst_test_regs
    import bst_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire bst_pkg::bst_tap_t tap,
    output logic               tdo,
    output logic               tdo_en,
    input  wire logic [7:0]    pin_data_in,
    input  wire logic [1:0]    pin_oe_n_in,
    output logic [7:0]         pin_data_out,
    output logic [7:0]         pin_data_oe,
    output logic               test_mode
);
    import bst_pkg::*;

    // Two-flop synchronisers for the pins
    logic [9:0] pin_s1_reg;
    logic [9:0] pin_s2_reg;
    logic [7:0] a_pin;
    logic [1:0] oe_n_pin;
    always_ff @(posedge clk_sys) begin
        pin_s1_reg <= {pin_oe_n_in, pin_data_in};
        pin_s2_reg <= pin_s1_reg;
    end
    assign a_pin    = pin_s2_reg[7:0];
    assign oe_n_pin = pin_s2_reg[9:8];

    function automatic logic [15:0] lfsr16(input logic [15:0] s);
        lfsr16 = {s[14:0], 1'b0} ^ (s[15] ? TAPS16 : 16'h0000);
    endfunction : lfsr16

    function automatic logic [7:0] lfsr8(input logic [7:0] s);
        lfsr8 = {s[6:0], 1'b0} ^ (s[7] ? TAPS8 : 8'h00);
    endfunction : lfsr8

    // Instruction holder
    logic [IR_W-1:0] ir_sh_reg;
    logic [IR_W-1:0] ir_sh_next;
    logic [IR_W-1:0] ir_reg;
    logic [IR_W-1:0] ir_next;
    always_comb begin
        ir_sh_next = ir_sh_reg;
        ir_next    = ir_reg;
        if (tap.tlr) begin
            ir_sh_next = IR_RESET;
            ir_next    = IR_RESET;
        end else if (tap.capture_ir) begin
            ir_sh_next = IR_CAPTURE;
        end else if (tap.shift_ir) begin
            ir_sh_next = {tap.tdi, ir_sh_reg[IR_W-1:1]};
        end else if (tap.update_ir) begin
            ir_next = ir_sh_reg;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ir_sh_reg <= IR_RESET;
            ir_reg    <= IR_RESET;
        end else begin
            ir_sh_reg <= ir_sh_next;
            ir_reg    <= ir_next;
        end
    end

    // Decode
    logic [OPC_W-1:0] opc;
    bst_dsel_t        dsel;
    bst_mode_t        mode;
    assign opc = ir_reg[OPC_W-1:0];
    always_comb begin
        dsel = DS_SHORT;
        mode = MD_NORMAL;
        case (opc)
            OPC_EXTEST, OPC_INTEST: begin
                dsel = DS_CHAIN;
                mode = MD_TEST;
            end
            OPC_SAMPLE, OPC_READ_N, OPC_SELFCHK: begin
                dsel = DS_CHAIN;
            end
            OPC_READ_T: begin
                dsel = DS_CHAIN;
                mode = MD_TEST;
            end
            OPC_FLOAT: mode = MD_FLOAT;
            OPC_HOLD, OPC_RUN_BOUNDARY_TEST, OPC_TOGGLE: mode = MD_TEST;
            OPC_OPSEL_N: dsel = DS_OPSEL;
            OPC_OPSEL_T: begin
                dsel = DS_OPSEL;
                mode = MD_TEST;
            end
            default: begin
                dsel = DS_SHORT;
                mode = MD_NORMAL;
            end
        endcase
    end
    assign test_mode = (mode == MD_TEST);

    // Data registers
    logic [CHAIN_W-1:0] chain_reg;
    logic [CHAIN_W-1:0] chain_next;
    logic [CHAIN_W-1:0] shadow_reg;
    logic [CHAIN_W-1:0] shadow_next;
    logic [OPS_W-1:0]   ops_sh_reg;
    logic [OPS_W-1:0]   ops_sh_next;
    logic [OPS_W-1:0]   ops_reg;
    logic [OPS_W-1:0]   ops_next;
    logic               short_reg;
    logic               short_next;
    logic [7:0]         core_a;
    logic [7:0]         core_y;
    logic               run_op;
    logic               is_chain;

    // Core buffer is inverting; core inputs come from cells in test mode
    assign core_a   = (mode == MD_TEST) ? shadow_reg[IN_HI:IN_LO]
                                        : a_pin;
    assign core_y   = ~core_a;
    assign is_chain = (dsel == DS_CHAIN);
    assign run_op   = tap.run_idle && !tap.tlr;

    always_comb begin
        chain_next  = chain_reg;
        shadow_next = shadow_reg;
        if (tap.tlr) begin
            chain_next = chain_reg;
        end else if (tap.capture_dr && is_chain) begin
            case (opc)
                OPC_READ_N, OPC_READ_T: chain_next = chain_reg;
                OPC_SELFCHK: chain_next = ~shadow_reg;
                default: begin
                    chain_next[OE_HI:OE_LO]   = oe_n_pin;
                    chain_next[IN_HI:IN_LO]   = a_pin;
                    chain_next[OUT_HI:OUT_LO] = core_y;
                end
            endcase
        end else if (tap.shift_dr && is_chain) begin
            chain_next = {tap.tdi, chain_reg[CHAIN_W-1:1]};
        end else if (tap.update_dr && is_chain) begin
            shadow_next = chain_reg;
        end else if (run_op && opc == OPC_TOGGLE) begin
            chain_next[OUT_HI:OUT_LO] = ~chain_reg[OUT_HI:OUT_LO];
            shadow_next[OUT_HI:OUT_LO] = chain_next[OUT_HI:OUT_LO];
        end else if (run_op && opc == OPC_RUN_BOUNDARY_TEST) begin
            case (ops_reg)
                OPS_TOGGLE: begin
                    chain_next[IN_HI:IN_LO]   = a_pin;
                    chain_next[OUT_HI:OUT_LO] = ~chain_reg[OUT_HI:OUT_LO];
                end
                OPS_PATTERN: begin
                    chain_next[IN_HI:OUT_LO] = lfsr16(chain_reg[IN_HI:OUT_LO]);
                end
                OPS_SIGN: begin
                    chain_next[IN_HI:OUT_LO] = lfsr16(chain_reg[IN_HI:OUT_LO])
                                             ^ {a_pin, 8'h00};
                end
                OPS_BOTH: begin
                    chain_next[IN_HI:IN_LO] = lfsr8(chain_reg[IN_HI:IN_LO])
                                            ^ a_pin;
                    chain_next[OUT_HI:OUT_LO] =
                        lfsr8(chain_reg[OUT_HI:OUT_LO]);
                end
                default: chain_next = chain_reg;
            endcase
            // Signature mode keeps the output shadows frozen
            shadow_next[IN_HI:IN_LO] = chain_next[IN_HI:IN_LO];
            if (ops_reg != OPS_SIGN) begin
                shadow_next[OUT_HI:OUT_LO] = chain_next[OUT_HI:OUT_LO];
            end
        end
    end

    always_comb begin
        ops_sh_next = ops_sh_reg;
        ops_next    = ops_reg;
        short_next  = short_reg;
        if (tap.tlr) begin
            ops_sh_next = OPSEL_RESET;
            ops_next    = OPSEL_RESET;
        end else if (dsel == DS_OPSEL) begin
            // Capture leaves the select untouched
            if (tap.shift_dr) begin
                ops_sh_next = {tap.tdi, ops_sh_reg[OPS_W-1]};
            end else if (tap.update_dr) begin
                ops_next = ops_sh_reg;
            end
        end else if (dsel == DS_SHORT) begin
            if (tap.capture_dr) begin
                short_next = 1'b0;
            end else if (tap.shift_dr) begin
                short_next = tap.tdi;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            chain_reg  <= '0;
            shadow_reg <= '0;
            ops_sh_reg <= OPSEL_RESET;
            ops_reg    <= OPSEL_RESET;
            short_reg  <= 1'b0;
        end else begin
            chain_reg  <= chain_next;
            shadow_reg <= shadow_next;
            ops_sh_reg <= ops_sh_next;
            ops_reg    <= ops_next;
            short_reg  <= short_next;
        end
    end

    // Serial output and pin drivers
    logic       tdo_next;
    logic [7:0] dout_next;
    logic [7:0] doe_next;
    logic [1:0] grp_en;
    always_comb begin
        if (tap.shift_ir) begin
            tdo_next = ir_sh_reg[0];
        end else begin
            case (dsel)
                DS_CHAIN: tdo_next = chain_reg[0];
                DS_OPSEL: tdo_next = ops_sh_reg[0];
                DS_SHORT: tdo_next = short_reg;
                default:  tdo_next = short_reg;
            endcase
        end
        if (mode == MD_TEST) begin
            grp_en    = ~shadow_reg[OE_HI:OE_LO];
            dout_next = shadow_reg[OUT_HI:OUT_LO];
        end else begin
            grp_en    = ~oe_n_pin;
            dout_next = core_y;
        end
        if (mode == MD_FLOAT) begin
            grp_en = 2'h0;
        end
        doe_next = {{4{grp_en[1]}}, {4{grp_en[0]}}};
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tdo          <= 1'b0;
            tdo_en       <= 1'b0;
            pin_data_out <= 8'h00;
            pin_data_oe  <= 8'h00;
        end else begin
            tdo          <= tdo_next;
            tdo_en       <= tap.shift_dr || tap.shift_ir;
            pin_data_out <= dout_next;
            pin_data_oe  <= doe_next;
        end
    end

    // Cell map and decode are written for these sizes only
    if (CHAIN_W != 18 || IR_W != 8) begin : g_width_check
        $error("Unsupported register widths");
    end

    // Checks stay off one more cycle: pin registers still hold reset values
    logic rst_d_reg;
    always_ff @(posedge clk_sys) begin
        rst_d_reg <= sys_rst;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || rst_d_reg);

    a_ir_reset: assert property (tap.tlr |=> ir_reg == IR_RESET)
        else $error("Instruction holder not reset");
    a_ir_capture: assert property (tap.capture_ir && !tap.tlr
        |=> ir_sh_reg == IR_CAPTURE)
        else $error("Wrong instruction capture");
    a_ops_reset: assert property (tap.tlr
        |=> ops_reg == OPSEL_RESET && ops_sh_reg == OPSEL_RESET)
        else $error("Operation select not reset");
    a_ops_hold: assert property (tap.capture_dr && !tap.tlr
        && dsel == DS_OPSEL |=> ops_sh_reg == $past(ops_sh_reg))
        else $error("Operation select changed at capture");
    a_short_zero: assert property (tap.capture_dr && !tap.tlr
        && dsel == DS_SHORT |=> short_reg == 1'b0)
        else $error("Shortcut stage did not capture zero");
    a_chain_tlr: assert property (tap.tlr
        |=> chain_reg == $past(chain_reg))
        else $error("Chain changed in reset state");
    a_chain_shift: assert property (tap.shift_dr && !tap.tlr && is_chain
        |=> chain_reg[OE_HI] == $past(tap.tdi)
        && chain_reg[OE_HI-1:0] == $past(chain_reg[OE_HI:1]))
        else $error("Chain shift order wrong");
    a_chain_capture: assert property (tap.capture_dr && !tap.tlr
        && (opc == OPC_EXTEST || opc == OPC_SAMPLE)
        |=> chain_reg[IN_HI:IN_LO] == $past(a_pin)
        && chain_reg[OE_HI:OE_LO] == $past(oe_n_pin)
        && chain_reg[OUT_HI:OUT_LO] == (opc == OPC_SAMPLE
            ? ~$past(a_pin) : ~$past(shadow_reg[IN_HI:IN_LO])))
        else $error("Boundary capture wrong");
    a_test_drive: assert property (mode == MD_TEST
        |=> pin_data_out == $past(shadow_reg[OUT_HI:OUT_LO]))
        else $error("Output pins not driven from cells");
    a_normal_path: assert property (mode == MD_NORMAL ##1 mode == MD_NORMAL
        |-> pin_data_out == ~$past(a_pin))
        else $error("Buffer function disturbed");
    a_msb_ignored: assert property ($past(ir_reg[6:0]) == ir_reg[6:0]
        |-> dsel == $past(dsel) && mode == $past(mode))
        else $error("Top opcode bit affects decode");
    a_float_off: assert property (mode == MD_FLOAT
        |=> pin_data_oe == 8'h00)
        else $error("Outputs driven in float mode");
    a_short_shift: assert property (tap.shift_dr && !tap.tlr
        && !tap.capture_dr && dsel == DS_SHORT |=> short_reg == $past(tap.tdi))
        else $error("Shortcut stage shift wrong");
    a_tdo_chain: assert property (tap.shift_dr && !tap.shift_ir
        && is_chain |=> tdo == $past(chain_reg[0]))
        else $error("Serial output not chain bit zero");
    a_ops_update: assert property (tap.update_dr && !tap.tlr
        && !tap.shift_dr && dsel == DS_OPSEL |=> ops_reg == $past(ops_sh_reg))
        else $error("Operation select update wrong");

    c_ir_load: cover property (tap.update_ir ##1 opc == OPC_RUN_BOUNDARY_TEST);
    c_run_test: cover property (opc == OPC_RUN_BOUNDARY_TEST && tap.run_idle);
    c_chain_scan: cover property (is_chain && tap.shift_dr [*3]);
    c_float: cover property (mode == MD_FLOAT && pin_data_oe == 8'h00);
    c_opsel_update: cover property (tap.update_dr && dsel == DS_OPSEL);
endmodule : bst_test_regs
`default_nettype wire
